// File: cjx_decode.sv
// Decode/execute of the conditional jump with else data-memory transfer
// Function
// - Single lane: jump only when predicate true
// - False predicate: do transfer and compute instead
// - Relative form adds 6-bit offset to PC
// - Indirect target is index plus step, no writeback
// - No delay, loop exit or irq reuse
// - Transfer post-modifies index register with writeback
// - Dual lane: jump needs both predicates true
// - Dual lane: each element transfers when false
// - Secondary element uses complementary file register
// - Secondary address is primary index plus one
// - Broadcast read loads both element registers
// - Top field 110 indirect, 111 relative
// - Decode way, slot, index and step fields
// - Empty compute field acts as no-op
// - Omitted predicate means always true, else flag
// - Kind, delay bits; calls ignore exit, reuse
// - Predicate here always evaluated, never defaulted
`timescale 1ns/1ps
module cjx_decode
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic issue_in,
  input wire logic [47:0] instr_in,
  input wire logic [23:0] pc_in,
  input wire logic dual_lane_mode_in,
  input wire logic [31:0] system_control_word_in,
  input wire logic pri_pred_in,
  input wire logic sec_pred_in,
  input wire logic [31:0] xfer_index_reg_in,
  input wire logic [31:0] xfer_step_reg_in,
  input wire logic [23:0] jump_index_reg_in,
  input wire logic [23:0] jump_step_reg_in,
  output logic [4:0] test_predicate_out,
  output logic [2:0] xfer_index_sel_out,
  output logic [2:0] xfer_step_sel_out,
  output logic [2:0] jump_index_sel_out,
  output logic [2:0] jump_step_sel_out,
  output logic [5:0] pc_offset_field_out,
  output cjx_pkg::cjx_prev_type prev_dec_out,
  output logic valid_out,
  output cjx_pkg::cjx_jump_type jump_out,
  output logic delayed_branch_modifier_out,
  output logic loop_exit_modifier_out,
  output logic pending_irq_reuse_out,
  output cjx_pkg::cjx_xfer_type xfer_out,
  output logic xfer_index_we_out,
  output logic [31:0] xfer_index_wdata_out,
  output logic pri_compute_en_out,
  output logic sec_compute_en_out,
  output logic [22:0] compute_op_out
);
  typedef struct packed {
    logic valid;
    cjx_pkg::cjx_jump_type jump;
    cjx_pkg::cjx_xfer_type xfer;
    logic idx_we;
    logic [31:0] idx_wdata;
    logic pri_comp;
    logic sec_comp;
    logic [22:0] comp;
  } cjx_state_type;

  cjx_state_type state_r;
  cjx_state_type state_nxt;
  logic is_ind;
  logic is_rel;
  logic pri_false;
  logic sec_false;
  logic take;
  logic comp_present;

  function automatic logic [23:0] cjx_sext(input logic [5:0] ofs);
    cjx_sext = {{(cjx_pkg::PA_W - cjx_pkg::OFS_W){ofs[cjx_pkg::OFS_W-1]}}, ofs};
  endfunction

  // Field extractors shared by the decode and its checks
  function automatic logic [2:0] cjx_top(input logic [cjx_pkg::INSTR_W-1:0] w);
    cjx_top = w[cjx_pkg::TOP_HI:cjx_pkg::TOP_LO];
  endfunction

  function automatic logic [5:0] cjx_ofs(input logic [cjx_pkg::INSTR_W-1:0] w);
    cjx_ofs = w[cjx_pkg::OFS_HI:cjx_pkg::OFS_LO];
  endfunction

  function automatic logic [22:0] cjx_comp(input logic [cjx_pkg::INSTR_W-1:0] w);
    cjx_comp = w[cjx_pkg::COMP_HI:cjx_pkg::COMP_LO];
  endfunction

  cjx_prev_decode u_prev
  (
    .instr_in(instr_in),
    .dec_out(prev_dec_out)
  );

  assign test_predicate_out = instr_in[cjx_pkg::TEST_PREDICATE_HI:cjx_pkg::TEST_PREDICATE_LO];
  assign xfer_index_sel_out = instr_in[cjx_pkg::XI_HI:cjx_pkg::XI_LO];
  assign xfer_step_sel_out = instr_in[cjx_pkg::XS_HI:cjx_pkg::XS_LO];
  assign jump_index_sel_out = instr_in[cjx_pkg::JI_HI:cjx_pkg::JI_LO];
  assign jump_step_sel_out = instr_in[cjx_pkg::JS_HI:cjx_pkg::JS_LO];
  assign pc_offset_field_out = cjx_ofs(instr_in);

  always_comb
  begin
    is_ind = issue_in && (cjx_top(instr_in) == cjx_pkg::TOP_INDIRECT);
    is_rel = issue_in && (cjx_top(instr_in) == cjx_pkg::TOP_PCREL);
    // Predicate inputs are real evaluations; no always-true default here
    pri_false = ~pri_pred_in;
    sec_false = dual_lane_mode_in & ~sec_pred_in;
    take = pri_pred_in && (!dual_lane_mode_in || sec_pred_in);
    comp_present = (cjx_comp(instr_in) != cjx_pkg::COMP_NOP);
    state_nxt = '0;
    state_nxt.valid = is_ind || is_rel;
    if (is_ind || is_rel)
    begin
      state_nxt.jump.taken = take;
      if (is_rel)
      begin
        state_nxt.jump.target = pc_in + cjx_sext(cjx_ofs(instr_in));
      end
      else
      begin
        // Pre-modify only; index register is left untouched
        state_nxt.jump.target = jump_index_reg_in + jump_step_reg_in;
      end
      state_nxt.xfer.write = instr_in[cjx_pkg::WAY_BIT];
      state_nxt.xfer.slot = instr_in[cjx_pkg::SLOT_HI:cjx_pkg::SLOT_LO];
      state_nxt.xfer.pri_en = pri_false;
      state_nxt.xfer.sec_en = sec_false;
      state_nxt.xfer.pri_addr = xfer_index_reg_in;
      state_nxt.xfer.sec_addr = xfer_index_reg_in + cjx_pkg::SEC_ADDR_STEP;
      // Broadcast read fills secondary even in single lane
      state_nxt.xfer.bcast = pri_false && !instr_in[cjx_pkg::WAY_BIT]
        && system_control_word_in[cjx_pkg::BCAST_BIT];
      // Index updated whenever either element performs the access
      state_nxt.idx_we = pri_false || sec_false;
      state_nxt.idx_wdata = xfer_index_reg_in + xfer_step_reg_in;
      state_nxt.pri_comp = pri_false && comp_present;
      state_nxt.sec_comp = sec_false && comp_present;
      state_nxt.comp = cjx_comp(instr_in);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign valid_out = state_r.valid;
  assign jump_out = state_r.jump;
  assign xfer_out = state_r.xfer;
  assign xfer_index_we_out = state_r.idx_we;
  assign xfer_index_wdata_out = state_r.idx_wdata;
  assign pri_compute_en_out = state_r.pri_comp;
  assign sec_compute_en_out = state_r.sec_comp;
  assign compute_op_out = state_r.comp;
  // Modifiers are never offered on this jump
  assign delayed_branch_modifier_out = 1'b0;
  assign loop_exit_modifier_out = 1'b0;
  assign pending_irq_reuse_out = 1'b0;

  sequence s_issue_any;
    is_ind || is_rel;
  endsequence

  sequence s_issue_rel;
    is_rel;
  endsequence

  sequence s_issue_ind;
    is_ind;
  endsequence

  sequence s_single_issue;
    (is_ind || is_rel) && !dual_lane_mode_in;
  endsequence

  sequence s_dual_issue;
    (is_ind || is_rel) && dual_lane_mode_in;
  endsequence

  sequence s_pri_else;
    (is_ind || is_rel) && !pri_pred_in;
  endsequence

  sequence s_sec_else;
    (is_ind || is_rel) && dual_lane_mode_in && !sec_pred_in;
  endsequence

  sequence s_pri_compute;
    (is_ind || is_rel) && !pri_pred_in && comp_present;
  endsequence

  // No issue or a foreign top code must leave every answer idle
  sequence s_refused;
    !(is_ind || is_rel);
  endsequence

  property p_single_jump;
    @(posedge clock_in) disable iff (rst_in)
    s_single_issue |=> jump_out.taken == $past(pri_pred_in);
  endproperty
  jump_single_a: assert property (p_single_jump)
    else $error("single lane jump wrong");

  property p_else_xfer;
    @(posedge clock_in) disable iff (rst_in)
    valid_out |-> (jump_out.taken || xfer_out.pri_en || xfer_out.sec_en) && !(xfer_out.pri_en && jump_out.taken);
  endproperty
  else_xfer_a: assert property (p_else_xfer)
    else $error("transfer with taken jump");

  property p_pri_else;
    @(posedge clock_in) disable iff (rst_in)
    s_pri_else |=> xfer_out.pri_en && !jump_out.taken;
  endproperty
  pri_else_xfer_a: assert property (p_pri_else)
    else $error("false predicate did not transfer");

  property p_rel_target;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_rel |=> jump_out.target == $past(pc_in) + cjx_sext(cjx_ofs($past(instr_in)));
  endproperty
  rel_target_a: assert property (p_rel_target)
    else $error("relative target wrong");

  property p_ind_target;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_ind |=> jump_out.target == $past(jump_index_reg_in) + $past(jump_step_reg_in);
  endproperty
  ind_target_a: assert property (p_ind_target)
    else $error("indirect target wrong");

  property p_no_modifier;
    @(posedge clock_in) disable iff (rst_in)
    valid_out |-> !(delayed_branch_modifier_out || loop_exit_modifier_out || pending_irq_reuse_out);
  endproperty
  no_modifier_a: assert property (p_no_modifier)
    else $error("modifier asserted");

  property p_post_modify;
    @(posedge clock_in) disable iff (rst_in)
    s_pri_else |=> xfer_index_we_out && xfer_out.pri_addr == $past(xfer_index_reg_in)
      && xfer_index_wdata_out == $past(xfer_index_reg_in) + $past(xfer_step_reg_in);
  endproperty
  post_modify_a: assert property (p_post_modify)
    else $error("post modify wrong");

  property p_dual_jump;
    @(posedge clock_in) disable iff (rst_in)
    s_dual_issue |=> jump_out.taken == ($past(pri_pred_in) && $past(sec_pred_in));
  endproperty
  dual_jump_a: assert property (p_dual_jump)
    else $error("dual lane jump wrong");

  property p_dual_pri;
    @(posedge clock_in) disable iff (rst_in)
    s_dual_issue |=> xfer_out.pri_en == !$past(pri_pred_in);
  endproperty
  dual_pri_xfer_a: assert property (p_dual_pri)
    else $error("primary enable wrong");

  property p_dual_sec;
    @(posedge clock_in) disable iff (rst_in)
    s_dual_issue |=> xfer_out.sec_en == !$past(sec_pred_in);
  endproperty
  dual_lane_xfer_a: assert property (p_dual_sec)
    else $error("secondary enable wrong");

  property p_single_sec;
    @(posedge clock_in) disable iff (rst_in)
    s_single_issue |=> !xfer_out.sec_en && !sec_compute_en_out;
  endproperty
  single_sec_off_a: assert property (p_single_sec)
    else $error("secondary active in single lane");

  property p_slot;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_any |=> xfer_out.slot == $past(instr_in[cjx_pkg::SLOT_HI:cjx_pkg::SLOT_LO]);
  endproperty
  slot_pass_a: assert property (p_slot)
    else $error("file slot wrong");

  property p_sec_addr;
    @(posedge clock_in) disable iff (rst_in)
    valid_out |-> xfer_out.sec_addr == xfer_out.pri_addr + cjx_pkg::SEC_ADDR_STEP;
  endproperty
  sec_addr_a: assert property (p_sec_addr)
    else $error("secondary address wrong");

  property p_sec_index;
    @(posedge clock_in) disable iff (rst_in)
    s_sec_else |=> xfer_index_we_out && xfer_out.sec_addr == $past(xfer_index_reg_in) + cjx_pkg::SEC_ADDR_STEP;
  endproperty
  sec_index_a: assert property (p_sec_index)
    else $error("secondary index wrong");

  property p_bcast;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_any |=> xfer_out.bcast == $past(!pri_pred_in && !instr_in[cjx_pkg::WAY_BIT]
      && system_control_word_in[cjx_pkg::BCAST_BIT]);
  endproperty
  bcast_read_a: assert property (p_bcast)
    else $error("broadcast load wrong");

  property p_valid;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_any |=> valid_out;
  endproperty
  valid_form_a: assert property (p_valid)
    else $error("form not accepted");

  property p_refused;
    @(posedge clock_in) disable iff (rst_in)
    s_refused |=> !valid_out && !xfer_index_we_out && !jump_out.taken;
  endproperty
  refused_top_a: assert property (p_refused)
    else $error("refused word answered");

  property p_way;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_any |=> xfer_out.write == $past(instr_in[cjx_pkg::WAY_BIT]);
  endproperty
  way_pass_a: assert property (p_way)
    else $error("transfer way wrong");

  property p_compute_nop;
    @(posedge clock_in) disable iff (rst_in)
    valid_out && compute_op_out == cjx_pkg::COMP_NOP |-> !pri_compute_en_out && !sec_compute_en_out;
  endproperty
  compute_nop_a: assert property (p_compute_nop)
    else $error("nop compute enabled");

  property p_compute_run;
    @(posedge clock_in) disable iff (rst_in)
    s_pri_compute |=> pri_compute_en_out && compute_op_out == cjx_comp($past(instr_in));
  endproperty
  compute_run_a: assert property (p_compute_run)
    else $error("compute not run");

  property p_sign_ext;
    @(posedge clock_in) disable iff (rst_in)
    s_issue_rel |=> $signed(jump_out.target - $past(pc_in)) == $signed(cjx_ofs($past(instr_in)));
  endproperty
  sign_extend_a: assert property (p_sign_ext)
    else $error("offset not sign extended");

  property p_idle;
    @(posedge clock_in) disable iff (rst_in)
    !valid_out |-> xfer_out == '0 && !xfer_index_we_out && !pri_compute_en_out;
  endproperty
  idle_quiet_a: assert property (p_idle)
    else $error("idle outputs not clear");
endmodule

// File: cjx_pkg.sv
// Package: field layout, widths and types for the conditional jump / transfer decoder
package cjx_pkg;
  localparam int INSTR_W = 48;
  localparam int PA_W = 24;
  localparam int DA_W = 32;
  localparam int DATA_W = 40;
  localparam int TOP_HI = 47;
  localparam int TOP_LO = 45;
  localparam logic [2:0] TOP_INDIRECT = 3'h6;
  localparam logic [2:0] TOP_PCREL = 3'h7;
  localparam int WAY_BIT = 44;
  localparam int XI_HI = 43;
  localparam int XI_LO = 41;
  localparam int XS_HI = 40;
  localparam int XS_LO = 38;
  localparam int TEST_PREDICATE_HI = 37;
  localparam int TEST_PREDICATE_LO = 33;
  localparam int JI_HI = 32;
  localparam int JI_LO = 30;
  localparam int JS_HI = 29;
  localparam int JS_LO = 27;
  localparam int OFS_HI = 32;
  localparam int OFS_LO = 27;
  localparam int OFS_W = 6;
  localparam int SLOT_HI = 26;
  localparam int SLOT_LO = 23;
  localparam int COMP_HI = 22;
  localparam int COMP_LO = 0;
  localparam logic [22:0] COMP_NOP = 23'h000000;
  localparam int PREV_TEST_PREDICATE_HI = 37;
  localparam int PREV_TEST_PREDICATE_LO = 33;
  localparam logic [4:0] TEST_PREDICATE_ALWAYS = 5'h1f;
  localparam int PREV_ELSE_BIT = 25;
  localparam int PREV_KIND_BIT = 39;
  localparam int PREV_DELAY_BIT = 26;
  localparam int PREV_ABORT_BIT = 38;
  localparam int PREV_REUSE_BIT = 24;
  localparam int BCAST_BIT = 21;
  localparam logic [DA_W-1:0] SEC_ADDR_STEP = 32'h00000001;

  typedef struct packed {
    logic taken;
    logic [PA_W-1:0] target;
  } cjx_jump_type;

  typedef struct packed {
    logic pri_en;
    logic sec_en;
    logic write;
    logic [DA_W-1:0] pri_addr;
    logic [DA_W-1:0] sec_addr;
    logic [3:0] slot;
    logic bcast;
  } cjx_xfer_type;

  typedef struct packed {
    logic always_true;
    logic has_else;
    logic is_call;
    logic delayed;
    logic loop_exit;
    logic irq_reuse;
  } cjx_prev_type;
endpackage

// File: cjx_prev_decode.sv
// Field decoder for the preceding indirect jump/call instruction
`timescale 1ns/1ps
module cjx_prev_decode
(
  input wire logic [47:0] instr_in,
  output cjx_pkg::cjx_prev_type dec_out
);
  always_comb
  begin
    dec_out.always_true = (instr_in[cjx_pkg::PREV_TEST_PREDICATE_HI:cjx_pkg::PREV_TEST_PREDICATE_LO] == cjx_pkg::TEST_PREDICATE_ALWAYS);
    dec_out.has_else = instr_in[cjx_pkg::PREV_ELSE_BIT];
    dec_out.is_call = instr_in[cjx_pkg::PREV_KIND_BIT];
    dec_out.delayed = instr_in[cjx_pkg::PREV_DELAY_BIT];
    // Calls cannot abort loops or reuse an interrupt
    dec_out.loop_exit = instr_in[cjx_pkg::PREV_ABORT_BIT] & ~instr_in[cjx_pkg::PREV_KIND_BIT];
    dec_out.irq_reuse = instr_in[cjx_pkg::PREV_REUSE_BIT] & ~instr_in[cjx_pkg::PREV_KIND_BIT];
  end
endmodule

// File: cjx_regs_model.sv
// Register file model: index and step registers as seen by the decoder
`timescale 1ns/1ps
module cjx_regs_model
(
  input wire logic [2:0] xi_sel_in,
  input wire logic [2:0] xs_sel_in,
  input wire logic [2:0] ji_sel_in,
  input wire logic [2:0] js_sel_in,
  output logic [31:0] xi_out,
  output logic [31:0] xs_out,
  output logic [23:0] ji_out,
  output logic [23:0] js_out
);
  // Step 7 is negative and jump index near the top so both sums wrap
  assign xi_out = 32'h00000100 + {25'h0, xi_sel_in, 4'h0};
  assign xs_out = (xs_sel_in == 3'h7) ? 32'hfffffff0 : {29'h0, xs_sel_in};
  assign ji_out = 24'hfffff0 + {18'h0, ji_sel_in, 3'h0};
  assign js_out = {21'h0, js_sel_in} + 24'h000020;
endmodule

// File: tb_cjx_decode.sv
// Testbench for the conditional jump / else data transfer decoder
`timescale 1ns/1ps
module tb_cjx_decode;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic issue_in = 1'b0;
  logic [47:0] instr_in = 48'h0;
  logic [23:0] pc_in = 24'h000400;
  logic dual_lane_mode_in = 1'b0;
  logic [31:0] system_control_word_in = 32'h0;
  logic pri_pred_in = 1'b0;
  logic sec_pred_in = 1'b0;
  logic [31:0] xfer_index_reg_in, xfer_step_reg_in, xfer_index_wdata_out;
  logic [23:0] jump_index_reg_in, jump_step_reg_in;
  logic [4:0] test_predicate_out;
  logic [2:0] xfer_index_sel_out, xfer_step_sel_out, jump_index_sel_out, jump_step_sel_out;
  logic [5:0] pc_offset_field_out;
  cjx_pkg::cjx_prev_type prev_dec_out;
  cjx_pkg::cjx_jump_type jump_out;
  cjx_pkg::cjx_xfer_type xfer_out;
  logic valid_out, delayed_branch_modifier_out, loop_exit_modifier_out, pending_irq_reuse_out;
  logic xfer_index_we_out, pri_compute_en_out, sec_compute_en_out;
  logic [22:0] compute_op_out;
  int failures = 0;
  int checks_done = 0;
  // Row: taken, relative, write, compute, dual, pri pred, sec pred, broadcast, negative offset
  localparam logic [8:0] ROWS [9] = '{9'h128, 9'h0a3, 9'h044, 9'h18d, 9'h13c, 9'h0ba, 9'h074, 9'h093, 9'h026};

  cjx_decode dut (.clock_in, .rst_in, .issue_in, .instr_in, .pc_in, .dual_lane_mode_in, .system_control_word_in,
    .pri_pred_in, .sec_pred_in, .xfer_index_reg_in, .xfer_step_reg_in, .jump_index_reg_in, .jump_step_reg_in,
    .test_predicate_out, .xfer_index_sel_out, .xfer_step_sel_out, .jump_index_sel_out, .jump_step_sel_out,
    .pc_offset_field_out, .prev_dec_out, .valid_out, .jump_out, .delayed_branch_modifier_out,
    .loop_exit_modifier_out, .pending_irq_reuse_out, .xfer_out, .xfer_index_we_out, .xfer_index_wdata_out,
    .pri_compute_en_out, .sec_compute_en_out, .compute_op_out);
  cjx_regs_model regs (.xi_sel_in(xfer_index_sel_out), .xs_sel_in(xfer_step_sel_out),
    .ji_sel_in(jump_index_sel_out), .js_sel_in(jump_step_sel_out), .xi_out(xfer_index_reg_in),
    .xs_out(xfer_step_reg_in), .ji_out(jump_index_reg_in), .js_out(jump_step_reg_in));

  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic run_row(input logic [8:0] r, input int i);
    logic [47:0] w;
    logic [5:0] f;
    logic [31:0] a;
    logic [31:0] s;
    logic [23:0] t;
    logic pe;
    logic se;
    f = r[0] ? {1'b1, 5'(i - 1)} : 6'h1f - 6'(i);
    w = {r[7] ? 3'h7 : 3'h6, r[6], 3'(i), 3'(7 - i), 5'(30 + i), r[7] ? f : {3'(i + 1), 3'(i + 2)}, 4'(i + 3),
      r[5] ? 23'h400000 | 23'(i) : 23'h0};
    issue_in = 1'b1;
    pc_in = {14'h0001, 4'(i), 6'h00};
    instr_in = w;
    dual_lane_mode_in = r[4];
    pri_pred_in = r[3];
    sec_pred_in = r[2];
    system_control_word_in = {10'h0, r[1], 21'h0};
    #1;
    chk({xfer_index_sel_out, xfer_step_sel_out, test_predicate_out} === w[43:33], "fields");
    chk(r[7] ? pc_offset_field_out === f : {jump_index_sel_out, jump_step_sel_out} === w[32:27], "jsel");
    a = 32'h00000100 + {25'h0, w[43:41], 4'h0};
    s = (w[40:38] == 3'h7) ? 32'hfffffff0 : {29'h0, w[40:38]};
    t = r[7] ? pc_in + {{18{f[5]}}, f} : 24'hfffff0 + {18'h0, w[32:30], 3'h0} + {21'h0, w[29:27]} + 24'h000020;
    pe = ~r[3];
    se = r[4] & ~r[2];
    @(posedge clock_in);
    #2;
    chk(valid_out === 1'b1, "valid");
    chk(jump_out.taken === r[8], "taken");
    if (r[8])
      chk(jump_out.target === t, "target");
    chk(xfer_out.pri_en === pe && xfer_out.sec_en === se, "xfer enables");
    if (pe | se)
      chk(xfer_out.write === r[6] && xfer_out.slot === w[26:23], "way slot");
    if (pe)
      chk(xfer_out.pri_addr === a && xfer_out.bcast === (~r[6] & r[1]), "pri addr");
    if (se)
      chk(xfer_out.sec_addr === a + 32'h00000001, "sec addr");
    chk(xfer_index_we_out === (pe | se), "index we");
    if (pe | se)
      chk(xfer_index_wdata_out === a + s, "index wdata");
    chk(pri_compute_en_out === (pe & r[5]) && sec_compute_en_out === (se & r[5]), "compute");
    chk(compute_op_out === w[22:0], "compute op");
    chk({delayed_branch_modifier_out, loop_exit_modifier_out, pending_irq_reuse_out} === 3'h0, "mods");
  endtask

  initial
  begin
    logic [47:0] w;
    repeat (2) @(posedge clock_in);
    #2;
    chk(valid_out === 1'b0 && xfer_out === '0, "reset");
    rst_in = 1'b0;
    // Rows run back to back, one issue every cycle
    for (int i = 0; i < 9; i++)
      run_row(ROWS[i], i);
    instr_in = {3'h5, 45'h1fffffffffff};
    #1;
    @(posedge clock_in);
    #2;
    chk(valid_out === 1'b0 && jump_out === '0 && xfer_out === '0, "refused top code");
    issue_in = 1'b0;
    instr_in = {3'h6, 45'h0};
    @(posedge clock_in);
    #2;
    chk(valid_out === 1'b0 && xfer_index_we_out === 1'b0, "no issue");
    for (int k = 0; k < 8; k++)
    begin
      w = 48'h0;
      w[37:33] = k[0] ? 5'h1f : 5'(k);
      w[39] = k[1];
      w[38] = 1'b1;
      w[24] = 1'b1;
      w[26] = k[2];
      w[25] = k[0];
      instr_in = w;
      #1;
      chk(prev_dec_out.always_true === k[0] && prev_dec_out.has_else === k[0], "prev test_predicate");
      chk(prev_dec_out.is_call === k[1] && prev_dec_out.delayed === k[2], "prev kind");
      chk(prev_dec_out.loop_exit === ~k[1] && prev_dec_out.irq_reuse === ~k[1], "prev ignore");
    end
    // Reset in mid-run clears an answer that is standing
    @(posedge clock_in);
    #2;
    run_row(ROWS[0], 0);
    rst_in = 1'b1;
    #1;
    chk(valid_out === 1'b0 && jump_out === '0, "mid reset");
    // Release again and make sure the first issue after it is answered
    @(posedge clock_in);
    #2;
    rst_in = 1'b0;
    run_row(ROWS[4], 4);
    complete_run();
  end
endmodule
